// ### hdl/cmg_pkg.sv
// Shared constants for the CAN transceiver mode guard
package cmg_pkg;
  // Time base
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Dominant time-out duration in ns (plain default)
  localparam int unsigned DOM_TIMEOUT_NS = 1000000;
  // Least time, so rounded up to whole cycles
  localparam int unsigned DOM_TIMEOUT_CYC =
    (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Timer width
  localparam int unsigned TMR_W = 16;
  // Receive line level when the bus is recessive or disengaged
  localparam logic RX_RECESSIVE = 1'h1;
  // Reset level of the mode pin and fault synchroniser stages (no fault, normal mode)
  localparam logic [1:0] SYNC_RST = 2'h0;
endpackage

// ### hdl/cmg_timer_if.sv
// Link between the mode guard and its dominant time-out timer
`timescale 1ns/1ps
interface cmg_timer_if;
  logic tx_low;   // Controller transmit line is low
  logic expired;  // Dominant time-out has run out
  // Guard side
  modport guard (output tx_low, input expired);
  // Timer side
  modport timer (input tx_low, output expired);
endinterface

// ### hdl/cmg_dom_timer.sv
// Dominant time-out timer of the CAN transceiver mode guard
`timescale 1ns/1ps
module cmg_dom_timer #(
  parameter logic [cmg_pkg::TMR_W-1:0] LIMIT =
    cmg_pkg::TMR_W'(cmg_pkg::DOM_TIMEOUT_CYC)
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Link to the guard
  cmg_timer_if.timer      tmr
);
  logic [cmg_pkg::TMR_W-1:0] count;    // Cycles spent low
  logic                      was_low;  // Line level one cycle ago
  logic                      expired;  // Time-out reached

  assign tmr.expired = expired;

  // Remember last level to see the high-to-low edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      was_low <= 1'h0;
    end else begin
      was_low <= tmr.tx_low;
    end
  end

  // Count while low, restart on the falling edge, clear when high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (!tmr.tx_low) begin
      count <= '0;
    end else if (!was_low) begin
      count <= {{(cmg_pkg::TMR_W-1){1'b0}}, 1'b1};
    end else if (count != LIMIT) begin
      count <= count + 1'b1;
    end
  end

  // Flag holds until the line returns high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      expired <= 1'h0;
    end else if (!tmr.tx_low) begin
      expired <= 1'h0;
    end else if (was_low && count == LIMIT - 1'b1) begin
      expired <= 1'h1;
    end
  end

  // Timer restarts at one after a falling edge
  timer_start_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    tmr.tx_low && !was_low |=> count == 1)
    else $error("timer did not restart on falling edge");

  // Line high clears count and flag
  timer_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !tmr.tx_low |=> count == 0 && !expired)
    else $error("timer not cleared while line high");

  // Expiry exactly at the limit
  timer_expire_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    was_low && tmr.tx_low && count == LIMIT - 1'b1 |=> expired)
    else $error("timer did not expire at limit");

  // Expiry persists while line stays low
  expire_hold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    expired && tmr.tx_low |=> expired)
    else $error("time-out flag dropped while line low");
endmodule

// ### hdl/cmg_mode_guard.sv
// Digital mode guard of an on-chip high-speed CAN transceiver
// Behaviour
// - Silent-select low: transmit and receive normally
// - Bus state delivered on controller receive line
// - Silent-select high: transmitter off, bus recessive
// - Silent mode keeps receiver and all else
// - Transmit falling edge starts dominant timer
// - Timer expiry disables transmitter, bus recessive
// - Transmit high clears and restarts timer
// - Undervoltage on either supply: off, zero load
// - Overtemperature disables drivers until it clears
`timescale 1ns/1ps
module cmg_mode_guard #(
  parameter logic [cmg_pkg::TMR_W-1:0] DOM_TIMEOUT_CYCLES =
    cmg_pkg::TMR_W'(cmg_pkg::DOM_TIMEOUT_CYC)
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Mode pin
  input  wire logic silent_select_in,
  // CAN protocol controller side
  input  wire logic ctrl_tx_in,
  output logic      ctrl_rx_out,
  // Analog bus front end
  input  wire logic bus_rx_in,
  output logic      tx_drive_out,
  output logic      bus_load_out,
  // Protection monitors
  input  wire logic uv_vcc_in,
  input  wire logic uv_vio_in,
  input  wire logic overtemp_in,
  // Status
  output logic      dom_timeout_out
);
  logic [1:0] silent_sync;   // Mode pin synchroniser
  logic [1:0] rx_sync;       // Receiver comparator synchroniser
  logic [1:0] uv_vcc_sync;   // Core supply undervoltage synchroniser
  logic [1:0] uv_vio_sync;   // I/O supply undervoltage synchroniser
  logic [1:0] ot_sync;       // Overtemperature synchroniser
  logic       silent;        // Silent mode selected
  logic       engaged;       // Both supplies good
  logic       overtemp;      // Thermal shutdown limit exceeded
  logic       next_drive;    // Next transmitter drive level
  logic       next_rx;       // Next receive line level

  cmg_timer_if tmr_link ();

  // Two-stage synchronisers for every asynchronous input
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      silent_sync <= cmg_pkg::SYNC_RST;
      rx_sync     <= {2{cmg_pkg::RX_RECESSIVE}};
      uv_vcc_sync <= cmg_pkg::SYNC_RST;
      uv_vio_sync <= cmg_pkg::SYNC_RST;
      ot_sync     <= cmg_pkg::SYNC_RST;
    end else begin
      silent_sync <= {silent_sync[0], silent_select_in};
      rx_sync     <= {rx_sync[0], bus_rx_in};
      uv_vcc_sync <= {uv_vcc_sync[0], uv_vcc_in};
      uv_vio_sync <= {uv_vio_sync[0], uv_vio_in};
      ot_sync     <= {ot_sync[0], overtemp_in};
    end
  end

  // Clean internal levels from second stages
  assign silent   = silent_sync[1];
  assign engaged  = !uv_vcc_sync[1] && !uv_vio_sync[1];
  assign overtemp = ot_sync[1];

  // Dominant time-out timer, counted in time-base cycles
  assign tmr_link.tx_low = !ctrl_tx_in;
  cmg_dom_timer #(
    .LIMIT (DOM_TIMEOUT_CYCLES)
  ) u_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tmr      (tmr_link.timer)
  );

  // Transmitter drives dominant only when every guard allows
  always_comb begin
    next_drive = 1'h0;
    if (engaged && !silent && !overtemp && !tmr_link.expired) begin
      next_drive = !ctrl_tx_in;
    end
    // Silent, time-out, heat and undervoltage all leave it recessive
  end

  // Receive path runs in both modes; recessive while disengaged
  always_comb begin
    next_rx = cmg_pkg::RX_RECESSIVE;
    if (engaged) begin
      next_rx = rx_sync[1];
    end
  end

  // Registered transmitter drive
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_drive_out <= 1'h0;
    end else begin
      tx_drive_out <= next_drive;
    end
  end

  // Registered receive line to the controller
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_rx_out <= cmg_pkg::RX_RECESSIVE;
    end else begin
      ctrl_rx_out <= next_rx;
    end
  end

  // Bus load and status flags
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_load_out    <= 1'h0;
      dom_timeout_out <= 1'h0;
    end else begin
      bus_load_out    <= engaged;
      dom_timeout_out <= tmr_link.expired;
    end
  end

  // Normal mode with no fault passes the transmit level
  normal_drive_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !silent && engaged && !overtemp && !tmr_link.expired
      |=> tx_drive_out == !$past(ctrl_tx_in))
    else $error("normal mode did not follow transmit line");

  // Receive line follows the synchronised bus level
  rx_follow_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    engaged |=> ctrl_rx_out == $past(rx_sync[1]))
    else $error("receive line did not follow bus");

  // Silent mode never drives the bus
  silent_quiet_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    silent |=> !tx_drive_out)
    else $error("transmitter drove in silent mode");

  // Silent mode still receives and keeps the bus load
  silent_rx_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    silent && engaged
      |=> bus_load_out && ctrl_rx_out == $past(rx_sync[1]))
    else $error("receiver stopped in silent mode");

  // Time-out forces recessive
  timeout_off_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    tmr_link.expired |=> !tx_drive_out && dom_timeout_out)
    else $error("transmitter active after time-out");

  // Undervoltage removes drive and load, receive recessive
  uv_off_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !engaged |=> !tx_drive_out && !bus_load_out && ctrl_rx_out)
    else $error("device engaged during undervoltage");

  // Overtemperature disables the driver
  ot_off_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    overtemp |=> !tx_drive_out)
    else $error("driver active during overtemperature");

  // Core supply undervoltage disengages within three edges
  uv_core_off_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    uv_vcc_in |-> ##3 (!tx_drive_out && !bus_load_out))
    else $error("core undervoltage did not disengage");

  // I/O supply undervoltage disengages within three edges
  uv_io_off_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    uv_vio_in |-> ##3 (!tx_drive_out && !bus_load_out))
    else $error("I/O undervoltage did not disengage");

  // Both supplies good brings the load back
  uv_recover_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !uv_vcc_in && !uv_vio_in |-> ##3 bus_load_out)
    else $error("load not restored after supplies recovered");

  // Overtemperature pin releases the driver within three edges
  ot_latency_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    overtemp_in |-> ##3 !tx_drive_out)
    else $error("driver not released after overtemperature");

  // Silent pin releases the driver within three edges
  silent_latency_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    silent_select_in |-> ##3 !tx_drive_out)
    else $error("driver not released after silent select");

  // Silent pin with good supplies keeps the bus load
  silent_load_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    silent_select_in && !uv_vcc_in && !uv_vio_in |-> ##3 bus_load_out)
    else $error("bus load lost in silent mode");

  // A high transmit line never drives dominant
  recessive_tx_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ctrl_tx_in |=> !tx_drive_out)
    else $error("dominant driven while transmit high");

  // Status flag low while the timer has not run out
  status_clear_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !tmr_link.expired |=> !dom_timeout_out)
    else $error("time-out status set without expiry");

  // Recessive bus always reaches the controller as high
  rx_recessive_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    bus_rx_in |-> ##3 ctrl_rx_out)
    else $error("recessive bus not delivered");

  // Dominant bus reaches the controller while engaged
  rx_dominant_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !bus_rx_in && !uv_vcc_in && !uv_vio_in |-> ##3 !ctrl_rx_out)
    else $error("dominant bus not delivered");
endmodule

// ### bench/cmg_bus_model.sv
// Behavioural model of the differential bus seen by the transceiver
`timescale 1ns/1ps
module cmg_bus_model (
  // Transceiver side
  input  wire logic tx_drive_in,
  input  wire logic bus_load_in,
  // Another node pulling the bus dominant
  input  wire logic other_dom_in,
  // Comparator output, low is dominant
  output logic      bus_rx_out
);
  // Wired bus: any engaged driver makes it dominant, else recessive
  assign bus_rx_out = ~((tx_drive_in & bus_load_in) | other_dom_in);
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the CAN transceiver mode guard
`timescale 1ns/1ps
module tb_top;
  localparam int LIM = 20;          // Shortened dominant time-out
  logic clk_in    = 1'h0;           // Time base
  logic rst_n_in  = 1'h0;           // Reset, active low
  logic silent    = 1'h0;           // Mode pin
  logic ctrl_tx   = 1'h1;           // Controller transmit
  logic other_dom = 1'h0;           // Far node pulls dominant
  logic uv_vcc    = 1'h0;           // Core supply low
  logic uv_vio    = 1'h0;           // I/O supply low
  logic overtemp  = 1'h0;           // Too hot
  logic ctrl_rx, bus_rx, tx_drive, bus_load, dom_tmo;  // Observed
  int   err_count = 0;              // Mismatches
  int   tests_run = 0;              // Comparisons
  int   cycles    = 0;              // Watchdog count

  // Design under test with a short time-out
  cmg_mode_guard #(.DOM_TIMEOUT_CYCLES(16'h0014)) u_cmg_mode_guard (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .silent_select_in(silent),
    .ctrl_tx_in(ctrl_tx), .ctrl_rx_out(ctrl_rx), .bus_rx_in(bus_rx),
    .tx_drive_out(tx_drive), .bus_load_out(bus_load),
    .uv_vcc_in(uv_vcc), .uv_vio_in(uv_vio), .overtemp_in(overtemp),
    .dom_timeout_out(dom_tmo));

  // Bus partner
  cmg_bus_model u_cmg_bus_model (.tx_drive_in(tx_drive),
    .bus_load_in(bus_load), .other_dom_in(other_dom),
    .bus_rx_out(bus_rx));

  // 100 ns clock
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  // Let n edges pass, then settle just after the last
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Compare one output with its expected level
  task automatic chk(input logic exp, input logic got, input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Normal mode: drive and receive both work
  task automatic t_normal;
    ctrl_tx = 1'h0;
    step(1);
    chk(1'h1, tx_drive, "no drive in normal mode");
    step(4);
    chk(1'h0, ctrl_rx, "dominant not received");
    ctrl_tx = 1'h1;
    step(5);
    chk(1'h1, ctrl_rx, "recessive not received");
  endtask

  // Silent mode: no drive, receiver still follows the bus
  task automatic t_silent;
    silent = 1'h1;
    step(4);
    ctrl_tx = 1'h0;
    step(2);
    chk(1'h0, tx_drive, "drive in silent mode");
    other_dom = 1'h1;
    step(4);
    chk(1'h0, ctrl_rx, "receiver off in silent mode");
    other_dom = 1'h0;
    silent = 1'h0;
    step(4);
    chk(1'h1, tx_drive, "normal mode not resumed");
    ctrl_tx = 1'h1;
    step(2);
  endtask

  // Dominant time-out, its hold and its restart
  task automatic t_timeout;
    ctrl_tx = 1'h0;
    step(1);
    chk(1'h1, tx_drive, "drive missing");
    step(LIM - 3);
    chk(1'h1, tx_drive, "time-out too early");
    step(5);
    chk(1'h0, tx_drive, "time-out missing");
    chk(1'h1, dom_tmo, "time-out flag missing");
    step(10);
    chk(1'h0, tx_drive, "time-out not held");
    ctrl_tx = 1'h1;
    step(3);
    chk(1'h0, dom_tmo, "time-out not cleared");
    ctrl_tx = 1'h0;
    step(LIM - 3);
    ctrl_tx = 1'h1;
    step(10); // Bit time of ten clocks at the rate ceiling
    ctrl_tx = 1'h0;
    step(LIM - 3);
    chk(1'h1, tx_drive, "timer not restarted");
    ctrl_tx = 1'h1;
    step(3);
  endtask

  // Supply and temperature faults: 0 core, 1 I/O supply, 2 heat
  task automatic t_protect;
    for (int i = 0; i < 3; i++) begin
      uv_vcc = (i == 0);
      uv_vio = (i == 1);
      overtemp = (i == 2);
      ctrl_tx = 1'h0;
      other_dom = 1'h1;
      step(4);
      chk(1'h0, tx_drive, "drive during fault");
      chk(i == 2, bus_load, "load state wrong");
      chk(i != 2, ctrl_rx, "receive state wrong");
      {uv_vcc, uv_vio, overtemp} = 3'h0;
      step(4);
      chk(1'h1, tx_drive, "drive not restored");
      chk(1'h1, bus_load, "load not restored");
      ctrl_tx = 1'h1;
      other_dom = 1'h0;
      step(2);
    end
  endtask

  // Hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    step(5);
    rst_n_in = 1'h1;
    step(3);
    chk(1'h1, bus_load, "not engaged after reset");
    t_normal();
    t_silent();
    t_timeout();
    t_protect();
    test_done();
  end
endmodule
